// ---- hw/redundancy_pkg.sv ----
// constants shared by the standby redundancy controller files
package redundancy_pkg;

  // clock and wake response timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int WAKE_RESPONSE_NS = 100000;
  localparam int WAKE_RESPONSE_CYC = WAKE_RESPONSE_NS / CLK_PERIOD_NS;

  // role codes carried by the maker-specific role command
  localparam logic [7:0] ROLE_STANDARD = 8'h00;
  localparam logic [7:0] ROLE_ACTIVE = 8'h01;
  localparam logic [7:0] ROLE_STANDBY1 = 8'h02;
  localparam logic [7:0] ROLE_STANDBY2 = 8'h03;
  localparam logic [7:0] ROLE_STANDBY3 = 8'h04;
  localparam logic [7:0] ROLE_ALWAYS_STANDBY = 8'h05;
  localparam logic [7:0] ROLE_RESET = ROLE_STANDARD;

  // apb byte addresses
  localparam logic [7:0] ADDR_ROLE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LEVEL_BASE = 8'h08;
  localparam logic [7:0] ADDR_LEVEL_LAST = 8'h1C;
  localparam int LEVEL_COUNT = 6;

  // status word bit positions
  localparam int ST_WAKE_BUS = 0;
  localparam int ST_CONV_ON = 1;
  localparam int ST_STANDBY = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_LOAD_ON = 4;
  localparam int ST_REVERTED = 5;
  localparam int ST_LATE_WAKE = 6;
  localparam int ST_ROLE_LSB = 8;

  // level codes: 64 steps per volt, 8.0 V full load = 10'h200
  localparam int LEVEL_W = 10;
  localparam logic [9:0] LEVEL_FULL_SCALE = 10'h200;
  localparam logic [9:0] EN1_RESET = 10'h0CD;
  localparam logic [9:0] DIS1_RESET = 10'h05C;
  localparam logic [9:0] EN2_RESET = 10'h140;
  localparam logic [9:0] DIS2_RESET = 10'h0C1;
  localparam logic [9:0] EN3_RESET = 10'h1AD;
  localparam logic [9:0] DIS3_RESET = 10'h121;

  // operating state of this supply
  typedef enum logic [2:0] {
    ST_ON_FORCED = 3'b001,
    ST_ON_LOAD = 3'b010,
    ST_SLEEP = 3'b100
  } power_state_t;

endpackage

// ---- hw/sync_if.sv ----
// carrier between raw pin levels and their synchronised copies
`timescale 1ns/10ps
interface sync_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

// ---- hw/two_stage_sync.sv ----
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module two_stage_sync #(
  parameter int W = 4
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // asynchronous reset, active low
  sync_if.dst port // raw levels in, synced levels out
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  // first stage only feeds the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= port.raw;
      stage2_reg <= stage1_reg;
    end
  end

  assign port.synced = stage2_reg;

endmodule

// ---- hw/redundancy_standby_control.sv ----
// load-dependent standby control of one supply on a shared wake bus
`timescale 1ns/10ps
module redundancy_standby_control #(
  parameter int WAKE_LIMIT_CYC = redundancy_pkg::WAKE_RESPONSE_CYC
) (
  input wire logic SYS_CLK, // 125 MHz system clock
  input wire logic RESET_N, // asynchronous reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  input wire logic WAKE_BUS_I, // shared wake bus level
  output logic WAKE_BUS_O, // shared wake bus drive value
  output logic WAKE_BUS_OE, // shared wake bus drive enable
  input wire logic SHARE_ABOVE_EN, // load share above enable level
  input wire logic SHARE_BELOW_DIS, // load share below disable level
  input wire logic SUPPLY_FAULT, // internal fault seen
  input wire logic VOUT_UNDER, // output under fault threshold
  output logic [9:0] SHARE_EN_LEVEL, // enable level for comparator
  output logic [9:0] SHARE_DIS_LEVEL, // disable level for comparator
  output logic CONVERTER_ACTIVE_N // converter on, active low
);

  localparam int LW = redundancy_pkg::LEVEL_W;

  // synchronised pin levels: bus, two comparators, fault, undervoltage
  sync_if #(.W(5)) pins ();

  assign pins.raw = {VOUT_UNDER, SUPPLY_FAULT, SHARE_BELOW_DIS, SHARE_ABOVE_EN, WAKE_BUS_I};

  two_stage_sync #(.W(5)) u_sync (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .port(pins)
  );

  logic wake_bus_s;
  logic above_en_s;
  logic below_dis_s;
  logic fault_s;
  logic vout_under_s;

  // every decision below reads only synchronised copies
  assign wake_bus_s = pins.synced[0];
  assign above_en_s = pins.synced[1];
  assign below_dis_s = pins.synced[2];
  assign fault_s = pins.synced[3];
  assign vout_under_s = pins.synced[4];

  // role classification, used by several processes
  function automatic logic is_standby_role(input logic [7:0] r);
    is_standby_role = (r >= redundancy_pkg::ROLE_STANDBY1) &&
                      (r <= redundancy_pkg::ROLE_ALWAYS_STANDBY);
  endfunction

  function automatic logic is_valid_role(input logic [7:0] r);
    is_valid_role = (r <= redundancy_pkg::ROLE_ALWAYS_STANDBY);
  endfunction

  // level register index from a byte address, for read and write
  function automatic logic [2:0] level_index(input logic [7:0] a);
    logic [7:0] off;
    off = a - redundancy_pkg::ADDR_LEVEL_BASE;
    level_index = off[4:2];
  endfunction

  function automatic logic is_level_addr(input logic [7:0] a);
    is_level_addr = (a >= redundancy_pkg::ADDR_LEVEL_BASE) &&
                    (a <= redundancy_pkg::ADDR_LEVEL_LAST) && (a[1:0] == 2'b00);
  endfunction

  logic [7:0] role_reg;
  logic [LW-1:0] level_reg [redundancy_pkg::LEVEL_COUNT];
  logic wake_prev_reg;
  logic reverted_reg;
  logic load_on_reg;
  logic conv_on_reg;
  logic late_wake_reg;
  logic [13:0] wake_cnt_reg;
  redundancy_pkg::power_state_t state_reg;
  redundancy_pkg::power_state_t state_next;

  logic setup_phase;
  logic access_phase;
  logic addr_ok;
  logic wr_take;
  logic role_wr_ok;
  logic bus_fall;
  logic own_fault;
  logic standby_role;
  logic [2:0] pos_sel;

  // apb phases: zero wait states, answer in access phase
  assign setup_phase = PSEL && !PENABLE;
  assign access_phase = PSEL && PENABLE;
  assign addr_ok = (PADDR == redundancy_pkg::ADDR_ROLE) ||
                   (PADDR == redundancy_pkg::ADDR_STATUS) || is_level_addr(PADDR);
  assign wr_take = access_phase && PWRITE && addr_ok;
  // an out-of-range role byte is refused, not stored
  assign role_wr_ok = wr_take && (PADDR == redundancy_pkg::ADDR_ROLE) &&
                      is_valid_role(PWDATA[7:0]);
  assign PREADY = 1'b1;

  // error on unmapped address or an invalid role value
  always_comb begin
    PSLVERR = 1'b0;
    if (access_phase) begin
      if (!addr_ok) begin
        PSLVERR = 1'b1;
      end else if (PWRITE && (PADDR == redundancy_pkg::ADDR_ROLE) &&
                   !is_valid_role(PWDATA[7:0])) begin
        PSLVERR = 1'b1;
      end
    end
  end

  // high-to-low wake bus transition
  assign bus_fall = wake_prev_reg && !wake_bus_s;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wake_prev_reg <= 1'b0;
    end else begin
      wake_prev_reg <= wake_bus_s;
    end
  end

  // role byte; a standby role falls back to standard on a bus fall,
  // and that fall beats a write in the same cycle so no wake is missed
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      role_reg <= redundancy_pkg::ROLE_RESET;
    end else if (bus_fall && is_standby_role(role_reg)) begin
      role_reg <= redundancy_pkg::ROLE_STANDARD;
    end else if (role_wr_ok) begin
      role_reg <= PWDATA[7:0];
    end
  end

  // sticky revert flag, write one to clear; the set wins
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      reverted_reg <= 1'b0;
    end else if (bus_fall && is_standby_role(role_reg)) begin
      reverted_reg <= 1'b1;
    end else if (wr_take && (PADDR == redundancy_pkg::ADDR_STATUS) &&
                 PWDATA[redundancy_pkg::ST_REVERTED]) begin
      reverted_reg <= 1'b0;
    end
  end

  // programmable enable and disable levels per standby position
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      level_reg[0] <= redundancy_pkg::EN1_RESET;
      level_reg[1] <= redundancy_pkg::DIS1_RESET;
      level_reg[2] <= redundancy_pkg::EN2_RESET;
      level_reg[3] <= redundancy_pkg::DIS2_RESET;
      level_reg[4] <= redundancy_pkg::EN3_RESET;
      level_reg[5] <= redundancy_pkg::DIS3_RESET;
    end else if (wr_take && is_level_addr(PADDR)) begin
      level_reg[level_index(PADDR)] <= PWDATA[LW-1:0];
    end
  end

  // position selects the pair handed to the comparators
  always_comb begin
    case (role_reg)
      redundancy_pkg::ROLE_STANDBY2: pos_sel = 3'h1;
      redundancy_pkg::ROLE_STANDBY3: pos_sel = 3'h2;
      default: pos_sel = 3'h0;
    endcase
  end

  // levels from flops; comparator compares the load-share voltage
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SHARE_EN_LEVEL <= redundancy_pkg::EN1_RESET;
      SHARE_DIS_LEVEL <= redundancy_pkg::DIS1_RESET;
    end else begin
      SHARE_EN_LEVEL <= level_reg[{pos_sel[1:0], 1'b0}];
      SHARE_DIS_LEVEL <= level_reg[{pos_sel[1:0], 1'b1}];
    end
  end

  // hysteresis: woken by load above enable, released below disable;
  // comparators lag one cycle after a position change, harmless here
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      load_on_reg <= 1'b0;
    end else if (above_en_s) begin
      load_on_reg <= 1'b1;
    end else if (below_dis_s) begin
      load_on_reg <= 1'b0;
    end
  end

  assign standby_role = is_standby_role(role_reg);
  assign own_fault = fault_s || vout_under_s;

  // forced on unless standby role with a high bus and no own fault; bus high implies a
  // driving active peer, since an undriven bus is pulled low outside
  always_comb begin
    state_next = redundancy_pkg::ST_ON_FORCED;
    if (standby_role && wake_bus_s && !own_fault) begin
      if (role_reg == redundancy_pkg::ROLE_ALWAYS_STANDBY) begin
        state_next = redundancy_pkg::ST_SLEEP;
      end else if (load_on_reg || above_en_s) begin
        state_next = redundancy_pkg::ST_ON_LOAD;
      end else begin
        state_next = redundancy_pkg::ST_SLEEP;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= redundancy_pkg::ST_ON_FORCED;
    end else begin
      state_reg <= state_next;
    end
  end

  // converter enable follows the state; roles 00h/01h always on
  always_comb begin
    case (state_reg)
      redundancy_pkg::ST_SLEEP: conv_on_reg = 1'b0;
      redundancy_pkg::ST_ON_LOAD: conv_on_reg = 1'b1;
      redundancy_pkg::ST_ON_FORCED: conv_on_reg = 1'b1;
      default: conv_on_reg = 1'b1;
    endcase
  end

  // converter output from a flop; bus low reaches it in four cycles
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CONVERTER_ACTIVE_N <= 1'b0;
    end else begin
      CONVERTER_ACTIVE_N <= !conv_on_reg;
    end
  end

  // wake bus drive: fault pulls low in every role
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WAKE_BUS_O <= 1'b0;
      WAKE_BUS_OE <= 1'b0;
    end else if (own_fault) begin
      WAKE_BUS_O <= 1'b0;
      WAKE_BUS_OE <= 1'b1;
    end else if (role_reg == redundancy_pkg::ROLE_ACTIVE) begin
      WAKE_BUS_O <= 1'b1;
      WAKE_BUS_OE <= 1'b1;
    end else begin
      WAKE_BUS_O <= 1'b0;
      WAKE_BUS_OE <= 1'b0;
    end
  end

  // watch for a converter still off long after the bus fell
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wake_cnt_reg <= 14'h0000;
    end else if (wake_bus_s || !CONVERTER_ACTIVE_N) begin
      wake_cnt_reg <= 14'h0000;
    end else if (wake_cnt_reg != 14'h3FFF) begin
      wake_cnt_reg <= wake_cnt_reg + 14'h0001;
    end
  end

  // sticky late-wake flag; cleared by write one, set wins
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      late_wake_reg <= 1'b0;
    end else if (wake_cnt_reg >= 14'(WAKE_LIMIT_CYC)) begin
      late_wake_reg <= 1'b1;
    end else if (wr_take && (PADDR == redundancy_pkg::ADDR_STATUS) &&
                 PWDATA[redundancy_pkg::ST_LATE_WAKE]) begin
      late_wake_reg <= 1'b0;
    end
  end

  // status word assembled from live state
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h00000000;
    status_word[redundancy_pkg::ST_WAKE_BUS] = wake_bus_s;
    status_word[redundancy_pkg::ST_CONV_ON] = !CONVERTER_ACTIVE_N;
    status_word[redundancy_pkg::ST_STANDBY] = (state_reg == redundancy_pkg::ST_SLEEP);
    status_word[redundancy_pkg::ST_FAULT] = own_fault;
    status_word[redundancy_pkg::ST_LOAD_ON] = load_on_reg;
    status_word[redundancy_pkg::ST_REVERTED] = reverted_reg;
    status_word[redundancy_pkg::ST_LATE_WAKE] = late_wake_reg;
    status_word[redundancy_pkg::ST_ROLE_LSB +: 8] = role_reg;
  end

  // read data captured in the setup cycle, held through access
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h00000000;
    end else if (setup_phase && !PWRITE) begin
      if (PADDR == redundancy_pkg::ADDR_ROLE) begin
        PRDATA <= {24'h000000, role_reg};
      end else if (PADDR == redundancy_pkg::ADDR_STATUS) begin
        PRDATA <= status_word;
      end else if (is_level_addr(PADDR)) begin
        PRDATA <= {22'h0, level_reg[level_index(PADDR)]};
      end else begin
        PRDATA <= 32'h00000000;
      end
    end
  end

endmodule

// ---- sim/peer_supplies.sv ----
// peer supplies on the shared wake bus, with the bus pull-down
`timescale 1ns/10ps
module peer_supplies (
  input wire logic dut_o, // block drive value
  input wire logic dut_oe, // block drive enable
  input wire logic active_peer, // healthy active-role peer
  input wire logic peer_fault, // faulty peer pulls low
  output logic wake // resolved bus level
);
  // a low driver wins; with nobody driving, the pull-down leaves every unit on
  always_comb begin
    if ((dut_oe && !dut_o) || peer_fault) begin
      wake = 1'b0;
    end else if ((dut_oe && dut_o) || active_peer) begin
      wake = 1'b1;
    end else begin
      wake = 1'b0;
    end
  end
endmodule

// ---- sim/redundancy_standby_props.sv ----
// assertions on the ports of the standby redundancy controller
`timescale 1ns/10ps
module redundancy_standby_props #(
  parameter int WAKE_LIMIT_CYC = redundancy_pkg::WAKE_RESPONSE_CYC
) (
  input wire logic SYS_CLK, // clock
  input wire logic RESET_N, // reset
  input wire logic PSEL, // apb
  input wire logic PENABLE, // apb
  input wire logic PWRITE, // apb
  input wire logic [7:0] PADDR, // apb
  input wire logic [31:0] PWDATA, // apb
  input wire logic [31:0] PRDATA, // apb
  input wire logic PREADY, // apb
  input wire logic PSLVERR, // apb
  input wire logic WAKE_BUS_I, // bus level
  input wire logic WAKE_BUS_O, // bus drive
  input wire logic WAKE_BUS_OE, // bus enable
  input wire logic SHARE_ABOVE_EN, // comparator
  input wire logic SHARE_BELOW_DIS, // comparator
  input wire logic SUPPLY_FAULT, // fault
  input wire logic VOUT_UNDER, // undervoltage
  input wire logic [9:0] SHARE_EN_LEVEL, // level
  input wire logic [9:0] SHARE_DIS_LEVEL, // level
  input wire logic CONVERTER_ACTIVE_N // converter
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  // bus checks; margins cover two sync flops plus state and output flops
  ready_always_a: assert property (PREADY)
    else $error("apb ready low");
  error_decode_a: assert property (PSEL && PENABLE |-> PSLVERR == (PADDR > 8'h1C
    || PADDR[1:0] != 2'h0 || (PWRITE && PADDR == 8'h00 && PWDATA[7:0] > 8'h05)))
    else $error("apb error flag wrong");
  unmapped_zero_a: assert property (PSEL && PENABLE && !PWRITE && PADDR > 8'h1C
    |-> PRDATA == 32'h0) else $error("unmapped read not zero");
  reset_state_a: assert property ($rose(RESET_N) |-> !CONVERTER_ACTIVE_N
    && !WAKE_BUS_OE && SHARE_EN_LEVEL == 10'h0CD && SHARE_DIS_LEVEL == 10'h05C)
    else $error("reset state wrong");
  fault_pull_a: assert property (SUPPLY_FAULT [*4] |=> WAKE_BUS_OE && !WAKE_BUS_O)
    else $error("fault does not pull bus low");
  under_pull_a: assert property (VOUT_UNDER [*4] |=> WAKE_BUS_OE && !WAKE_BUS_O)
    else $error("undervoltage does not pull bus low");
  bus_low_wake_a: assert property (!WAKE_BUS_I [*6] |=> !CONVERTER_ACTIVE_N)
    else $error("low bus leaves converter off");
  fault_keeps_on_a: assert property (SUPPLY_FAULT [*6] |=> !CONVERTER_ACTIVE_N)
    else $error("faulty unit sleeps");
  sleeper_no_drive_a: assert property (CONVERTER_ACTIVE_N |-> !(WAKE_BUS_OE && WAKE_BUS_O))
    else $error("sleeping unit drives bus high");
endmodule
bind redundancy_standby_control redundancy_standby_props #(.WAKE_LIMIT_CYC(WAKE_LIMIT_CYC))
  i_props (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .WAKE_BUS_I(WAKE_BUS_I), .WAKE_BUS_O(WAKE_BUS_O),
  .WAKE_BUS_OE(WAKE_BUS_OE), .SHARE_ABOVE_EN(SHARE_ABOVE_EN),
  .SHARE_BELOW_DIS(SHARE_BELOW_DIS), .SUPPLY_FAULT(SUPPLY_FAULT), .VOUT_UNDER(VOUT_UNDER),
  .SHARE_EN_LEVEL(SHARE_EN_LEVEL), .SHARE_DIS_LEVEL(SHARE_DIS_LEVEL),
  .CONVERTER_ACTIVE_N(CONVERTER_ACTIVE_N));

// ---- sim/tb_redundancy_standby_control.sv ----
// self-checking bench for the standby redundancy controller
`timescale 1ns/10ps
module tb_redundancy_standby_control;
  localparam int WL = 20;
  logic clk, rst_n, psel, penable, pwrite, fault, under, above, below, act_peer, peer_flt;
  logic pready, pslverr, wake, wake_o, wake_oe, conv_n, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] en_lvl, dis_lvl;
  logic [9:0] lvl [6] = '{10'h0CD, 10'h05C, 10'h140, 10'h0C1, 10'h1AD, 10'h121};
  int fail_count, checks_done;

  redundancy_standby_control #(.WAKE_LIMIT_CYC(WL)) i_dut (.SYS_CLK(clk), .RESET_N(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .WAKE_BUS_I(wake),
    .WAKE_BUS_O(wake_o), .WAKE_BUS_OE(wake_oe), .SHARE_ABOVE_EN(above),
    .SHARE_BELOW_DIS(below), .SUPPLY_FAULT(fault), .VOUT_UNDER(under),
    .SHARE_EN_LEVEL(en_lvl), .SHARE_DIS_LEVEL(dis_lvl), .CONVERTER_ACTIVE_N(conv_n));
  peer_supplies i_peer (.dut_o(wake_o), .dut_oe(wake_oe), .active_peer(act_peer),
    .peer_fault(peer_flt), .wake(wake));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no timeout here; pready high or the watchdog ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(a, 1'b1, d);
    chk_val(32'(err), 32'(e));
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk_val(32'(err), 32'h0);
    chk_val(rd, exp);
  endtask

  // bounded wait, the limit being the late-wake span given to the design
  task automatic wait_conv(input logic exp);
    int n;
    n = 0;
    while (conv_n !== exp && n < WL) begin
      @(posedge clk);
      n++;
    end
    chk_val(32'(conv_n), 32'(exp));
  endtask

  task automatic t_reset();
    rdc(8'h00, 32'h0);
    for (int i = 0; i < 6; i++) rdc(8'(8 + 4 * i), {22'h0, lvl[i]});
    apb(8'h20, 1'b0, 32'h0);
    chk_val({31'h0, err}, 32'h1);
    chk_val(rd, 32'h0);
    chk_val(32'(conv_n), 32'h0);
    $display("test reset done");
  endtask

  task automatic t_roles();
    int p;
    for (int r = 0; r < 6; r++) begin
      wr(8'h00, 32'(r), 1'b0);
      rdc(8'h00, 32'(r));
      p = (r >= 2 && r <= 4) ? r - 2 : 0;
      chk_val({22'h0, en_lvl}, {22'h0, lvl[2 * p]});
      chk_val({22'h0, dis_lvl}, {22'h0, lvl[2 * p + 1]});
    end
    wr(8'h00, 32'h6, 1'b1);
    rdc(8'h00, 32'h5);
    $display("test roles done");
  endtask

  task automatic t_hyst();
    wr(8'h00, 32'h2, 1'b0);
    wait_conv(1'b1);
    rdc(8'h04, 32'h00000205);
    wr(8'h08, 32'h0AB, 1'b0);
    rdc(8'h08, 32'h0AB);
    chk_val({22'h0, en_lvl}, 32'h0AB);
    above <= 1'b1;
    below <= 1'b0;
    wait_conv(1'b0);
    rdc(8'h04, 32'h00000213);
    above <= 1'b0;
    repeat (10) @(posedge clk);
    chk_val(32'(conv_n), 32'h0);
    below <= 1'b1;
    wait_conv(1'b1);
    $display("test hysteresis done");
  endtask

  // peer leaves the bus, pull-down makes it fall
  task automatic t_revert();
    act_peer <= 1'b0;
    wait_conv(1'b0);
    rdc(8'h00, 32'h0);
    apb(8'h04, 1'b0, 32'h0);
    chk_val({26'h0, rd[5], 4'h0, rd[0]}, 32'h20);
    wr(8'h04, 32'h20, 1'b0);
    apb(8'h04, 1'b0, 32'h0);
    chk_val(32'(rd[5]), 32'h0);
    act_peer <= 1'b1;
    $display("test revert done");
  endtask

  task automatic t_fault();
    wr(8'h00, 32'h1, 1'b0);
    repeat (6) @(posedge clk);
    chk_val({30'h0, wake_oe, wake_o}, 32'h3);
    fault <= 1'b1;
    repeat (6) @(posedge clk);
    chk_val({30'h0, wake_oe, wake_o}, 32'h2);
    fault <= 1'b0;
    wr(8'h00, 32'h0, 1'b0);
    repeat (6) @(posedge clk);
    chk_val({31'h0, wake_oe}, 32'h0);
    under <= 1'b1;
    repeat (6) @(posedge clk);
    chk_val({30'h0, wake_oe, wake_o}, 32'h2);
    under <= 1'b0;
    $display("test fault done");
  endtask

  task automatic t_always();
    above <= 1'b1;
    below <= 1'b0;
    wr(8'h00, 32'h5, 1'b0);
    wait_conv(1'b1);
    peer_flt <= 1'b1;
    wait_conv(1'b0);
    rdc(8'h00, 32'h0);
    peer_flt <= 1'b0;
    $display("test always standby done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    {rst_n, psel, penable, pwrite, fault, under, above, peer_flt} = 8'h00;
    {below, act_peer} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_roles();
    t_hyst();
    t_revert();
    t_fault();
    t_always();
    summarize();
  end
endmodule
